// [src/scc_pkg.sv]
// Package of offsets, field positions, reset and preset values for the statistics counter control block.
package scc_pkg;

    // Register byte offsets.
    localparam logic [11:0] SCC_CTRL_OFS   = 12'h100;
    localparam logic [11:0] SCC_STAT_OFS   = 12'h104;
    localparam logic [11:0] SCC_MASK_OFS   = 12'h10C;
    localparam logic [11:0] SCC_FRAME_OFS  = 12'h180;
    localparam logic [11:0] SCC_OCTET_OFS  = 12'h184;

    // Control register field positions.
    localparam int SCC_CTRL_CLEAR  = 0;
    localparam int SCC_CTRL_SAT    = 1;
    localparam int SCC_CTRL_COR    = 2;
    localparam int SCC_CTRL_FREEZE = 3;
    localparam int SCC_CTRL_PRESET = 4;
    localparam int SCC_CTRL_FULL   = 5;
    localparam int SCC_CTRL_W      = 6;

    // Reset values.
    localparam logic [5:0]  SCC_CTRL_RST = 6'h00;
    localparam logic [1:0]  SCC_STAT_RST = 2'h0;
    localparam logic [1:0]  SCC_MASK_RST = 2'h0;
    localparam logic [31:0] SCC_CNT_RST  = 32'h0000_0000;

    // Counter indices and preset values.
    localparam int SCC_NCNT      = 2;
    localparam int SCC_IDX_FRAME = 0;
    localparam int SCC_IDX_OCTET = 1;
    localparam logic [31:0] SCC_OCT_HALF = 32'h7FFF_F800;
    localparam logic [31:0] SCC_FRM_HALF = 32'h7FFF_FFF0;
    localparam logic [31:0] SCC_OCT_FULL = 32'hFFFF_F800;
    localparam logic [31:0] SCC_FRM_FULL = 32'hFFFF_FFF0;
    localparam logic [31:0] SCC_CNT_MAX  = 32'hFFFF_FFFF;
    localparam int SCC_HALF_BIT = 31;

endpackage

// [src/scc_stat_counter_control.sv]
// Statistics counter control register, two representative receive counters and their interrupt logic.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] Half preset: octets 7FFF_F800, frames 7FFF_FFF0
// [R2] Full preset: octets FFFF_F800, frames FFFF_FFF0
// [R3] Bit 4 presets all, self-clears after one cycle
// [R4] Bit 3 freezes counting until written zero
// [R5] Frozen counters still clear on read
// [R6] Clear-on-read triggered by low byte lane read
// [R7] Bit 1 makes counters saturate at maximum
// [R8] Bit 0 clears all, self-clears after one cycle
// [R9] Bits 31:6 read zero, ignore writes
// [R10] Counters read-only, zero after reset
// [R11] Receive counters flag at half and maximum
// [R12] Clear or preset beats frame increment
module scc_stat_counter_control
    import scc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [31:0] rdata,
    input  wire logic        rxFrameDone,
    input  wire logic [15:0] rxFrameBytes,
    output var  logic        counterClear,
    output var  logic        counterPreset,
    output var  logic        presetFull,
    output var  logic        counterFreeze,
    output var  logic        counterSaturate,
    output var  logic        clearOnRead,
    output var  logic        irq
);

    // Register map on the byte address port. The control word sits at the base offset with six
    // live bits, two of them self-clearing triggers. A trigger reads back as one only in the single
    // cycle it stands, so a read strobed right after the write still sees it.
    // The status word follows, one sticky flag per counter, cleared by writing ones to it.
    // The mask word lets a flagged counter reach the interrupt where its bit is one.
    // The frame and octet counters sit in the counter window and are read-only.
    // Any other address reads as zero and drops writes, so software that probes the gaps
    // changes nothing.
    // A read answers one cycle after its strobe and the bus never waits, so a master may issue
    // strobes back to back.

    // Architectural registers, their next values and the decoded strobes.
    logic [5:0]  ctrl_reg;
    logic [1:0]  stat_reg;
    logic [1:0]  mask_reg;
    logic [31:0] rdata_reg;
    logic        irq_reg;
    logic [31:0] cnt_reg [SCC_NCNT];
    logic [31:0] incAmt  [SCC_NCNT];
    logic [31:0] presetVal [SCC_NCNT];
    logic [SCC_NCNT-1:0] cntRead;
    logic [SCC_NCNT-1:0] cntEvent;
    logic        ctrlWr;
    logic        statWr;
    logic        maskWr;
    logic [5:0]  ctrl_next;
    logic [1:0]  stat_next;
    logic [1:0]  statClr;
    logic [1:0]  mask_next;
    logic        irq_next;
    logic [31:0] rdata_next;

    // Address decode for writes. The full byte address is compared, so no register shows up
    // again at a mirrored offset.
    assign ctrlWr = wr && (addr == SCC_CTRL_OFS);
    assign statWr = wr && (addr == SCC_STAT_OFS);
    assign maskWr = wr && (addr == SCC_MASK_OFS);

    // A read of a counter word always covers its low byte lane on this port.
    assign cntRead[SCC_IDX_FRAME] = rd && (addr == SCC_FRAME_OFS); // [R6]
    assign cntRead[SCC_IDX_OCTET] = rd && (addr == SCC_OCTET_OFS); // [R6]

    // Per-counter increment amount. The byte count only matters beside a frame pulse, so the port
    // may carry stale values between frames.
    assign incAmt[SCC_IDX_FRAME] = {31'h0000_0000, rxFrameDone};
    assign incAmt[SCC_IDX_OCTET] = rxFrameDone ? {16'h0000, rxFrameBytes} : 32'h0000_0000;

    // Preset values follow the full/half select.
    // The select is read in the trigger cycle, so one control write may set both.
    assign presetVal[SCC_IDX_FRAME] = ctrl_reg[SCC_CTRL_FULL] ? SCC_FRM_FULL : SCC_FRM_HALF; // [R1] [R2]
    assign presetVal[SCC_IDX_OCTET] = ctrl_reg[SCC_CTRL_FULL] ? SCC_OCT_FULL : SCC_OCT_HALF; // [R1] [R2]

    // Next control value. A write replaces the six live bits; reserved bits of the word are never
    // stored, so they cannot read back. Without a write only the two triggers drop, which makes
    // each trigger a pulse of exactly one cycle however long software waits before its next access.
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrlWr)
        begin
            ctrl_next = wdata[SCC_CTRL_W-1:0]; // [R9]
        end
        else
        begin
            ctrl_next[SCC_CTRL_CLEAR]  = 1'b0; // [R8]
            ctrl_next[SCC_CTRL_PRESET] = 1'b0; // [R3]
        end
    end

    // Control register.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ctrl_reg <= SCC_CTRL_RST;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Counter bank. Clear and preset outrank a read clear, which outranks counting, so a frame that
    // lands on a trigger cycle is lost on purpose: the trigger defines the new starting value. A read
    // clear likewise swallows a frame in the same cycle, which software sees as one frame missing.
    // Only two receive counters are kept here; the rest of the array follows the common controls.
    generate
        for (genvar i = 0; i < SCC_NCNT; i++)
        begin : g_cnt
            logic [32:0] sum;
            logic [31:0] cntStep;
            logic [31:0] cnt_next;
            logic        halfHit;
            logic        fullHit;
            logic        readClear;
            logic        countEn;

            assign sum = {1'b0, cnt_reg[i]} + {1'b0, incAmt[i]};

            // Saturation clamps a carry to the top value instead of wrapping. A wrapped counter
            // would look freshly cleared to software, which saturation rules out.
            always_comb
            begin
                cntStep = sum[31:0];
                if (sum[32] && ctrl_reg[SCC_CTRL_SAT])
                begin
                    cntStep = SCC_CNT_MAX; // [R7]
                end
            end

            // A read clears only with clear-on-read on, and a frozen bank still honours it.
            assign readClear = cntRead[i] && ctrl_reg[SCC_CTRL_COR]; // [R5] [R6]

            // Counting needs no trigger, no read clear and no freeze in this cycle.
            assign countEn = !ctrl_reg[SCC_CTRL_CLEAR] && !ctrl_reg[SCC_CTRL_PRESET] && !readClear
                             && !ctrl_reg[SCC_CTRL_FREEZE]; // [R4] [R12]

            // Crossing into the upper half or arriving at the top both raise the flag. Loads from a
            // trigger never raise it, so a preset only places the counter just short of the mark.
            assign halfHit = !cnt_reg[i][SCC_HALF_BIT] && cntStep[SCC_HALF_BIT];
            assign fullHit = (cnt_reg[i] != SCC_CNT_MAX) && (cntStep == SCC_CNT_MAX || sum[32]);
            assign cntEvent[i] = countEn && (incAmt[i] != 32'h0000_0000) && (halfHit || fullHit); // [R11]

            // Next count in priority order: reset trigger, preset trigger, read clear, counting.
            always_comb
            begin
                cnt_next = cnt_reg[i];
                if (ctrl_reg[SCC_CTRL_CLEAR])
                begin
                    cnt_next = SCC_CNT_RST; // [R8] [R12]
                end
                else if (ctrl_reg[SCC_CTRL_PRESET])
                begin
                    cnt_next = presetVal[i]; // [R3] [R12]
                end
                else if (readClear)
                begin
                    cnt_next = SCC_CNT_RST; // [R5] [R6]
                end
                else if (!ctrl_reg[SCC_CTRL_FREEZE])
                begin
                    cnt_next = cntStep; // [R4]
                end
            end

            // Counter register, zero out of reset.
            always_ff @(posedge clock)
            begin
                if (!nrst)
                begin
                    cnt_reg[i] <= SCC_CNT_RST; // [R10]
                end
                else
                begin
                    cnt_reg[i] <= cnt_next;
                end
            end
        end
    endgenerate

    // Write-one-clear bits of the status word; only a write to the status offset clears.
    assign statClr = statWr ? wdata[1:0] : 2'h0;

    // Next status. The clear is applied before the set, so an event that lands in the cycle of a
    // clear survives and software never loses a flag it has not yet seen.
    always_comb
    begin
        stat_next = (stat_reg & ~statClr) | cntEvent; // [R11]
    end

    // Sticky interrupt status.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            stat_reg <= SCC_STAT_RST;
        end
        else
        begin
            stat_reg <= stat_next;
        end
    end

    // Next mask: replaced whole by a mask write, held otherwise.
    always_comb
    begin
        mask_next = mask_reg;
        if (maskWr)
        begin
            mask_next = wdata[1:0];
        end
    end

    // Interrupt mask, a one lets the matching status bit through.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            mask_reg <= SCC_MASK_RST;
        end
        else
        begin
            mask_reg <= mask_next;
        end
    end

    // Any flagged and enabled counter asks for service.
    assign irq_next = |(stat_reg & mask_reg);

    // Registered interrupt level, so it trails the status by one cycle. The extra cycle keeps the
    // pin free of decode glitches, at the cost of one cycle more before software is called.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    // Read mux. Only the cycle of the strobe selects a word; every other cycle yields zero so the
    // answer stands for exactly one cycle. Counters are read-only: writes to their offsets fall
    // through the write decode and are ignored.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (rd)
        begin
            unique case (addr)
                SCC_CTRL_OFS:  rdata_next = {26'h000_0000, ctrl_reg}; // [R9]
                SCC_STAT_OFS:  rdata_next = {30'h0000_0000, stat_reg};
                SCC_MASK_OFS:  rdata_next = {30'h0000_0000, mask_reg};
                SCC_FRAME_OFS: rdata_next = cnt_reg[SCC_IDX_FRAME]; // [R10]
                SCC_OCTET_OFS: rdata_next = cnt_reg[SCC_IDX_OCTET]; // [R10]
                default:       rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data register, holding the answer for the cycle after the strobe.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Common controls for the wider counter array, all straight from flip-flops.
    // Every counter outside this block sees the same trigger cycle, so the whole array moves together.
    assign rdata           = rdata_reg;
    assign irq             = irq_reg;
    assign counterClear    = ctrl_reg[SCC_CTRL_CLEAR];
    assign counterPreset   = ctrl_reg[SCC_CTRL_PRESET];
    assign presetFull      = ctrl_reg[SCC_CTRL_FULL];
    assign counterFreeze   = ctrl_reg[SCC_CTRL_FREEZE];
    assign counterSaturate = ctrl_reg[SCC_CTRL_SAT];
    assign clearOnRead     = ctrl_reg[SCC_CTRL_COR];

endmodule
`default_nettype wire

// [test/scc_ctrl_asserts.sv]
// Port assertions for the statistics counter control block.
`timescale 1ns/100ps
`default_nettype none
module scc_ctrl_asserts
    import scc_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        counterClear,
    input wire logic        counterPreset,
    input wire logic        presetFull,
    input wire logic        counterFreeze,
    input wire logic        counterSaturate,
    input wire logic        clearOnRead,
    input wire logic        irq
);
    // A write that lands in the control register.
    wire logic cw = wr && addr == SCC_CTRL_OFS;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence presetWr;
        cw && wdata[4];
    endsequence
    a_clear_pulse: assert property (cw && wdata[0] |=> counterClear) else $error("clear missing");
    a_clear_once: assert property (counterClear && !(cw && wdata[0]) |=> !counterClear) else $error("clear stuck");
    a_preset_once: assert property (presetWr ##1 !(cw && wdata[4]) |-> counterPreset ##1 !counterPreset)
        else $error("preset pulse bad");
    a_full_bit: assert property (cw |=> presetFull == $past(wdata[5])) else $error("full select bad");
    a_freeze_bit: assert property (cw |=> counterFreeze == $past(wdata[3])) else $error("freeze bad");
    a_freeze_hold: assert property (!cw |=> $stable(counterFreeze)) else $error("freeze moved");
    a_sat_bit: assert property (cw |=> counterSaturate == $past(wdata[1])) else $error("saturate bad");
    a_cor_bit: assert property (cw |=> clearOnRead == $past(wdata[2])) else $error("clear on read bad");
    a_rsvd_zero: assert property (rd && addr == SCC_CTRL_OFS |=> rdata[31:6] == 26'h0) else $error("reserved set");
    a_irq_off: assert property (wr && addr == SCC_MASK_OFS && wdata[1:0] == 2'h0 |=> ##1 !irq)
        else $error("irq not masked");
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the statistics counter control block.
`timescale 1ns/100ps
`default_nettype none
module tb
    import scc_pkg::*;
;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rxFrameDone = 1'b0;
    logic [15:0] rxFrameBytes = 16'h0;
    logic [31:0] rdata;
    logic        counterClear, counterPreset, presetFull, counterFreeze, counterSaturate, clearOnRead, irq;
    int          failures = 0;
    int          checked = 0;
    scc_stat_counter_control DUT
    (
        .clock           (clock),
        .nrst            (nrst),
        .addr            (addr),
        .wdata           (wdata),
        .wr              (wr),
        .rd              (rd),
        .rdata           (rdata),
        .rxFrameDone     (rxFrameDone),
        .rxFrameBytes    (rxFrameBytes),
        .counterClear    (counterClear),
        .counterPreset   (counterPreset),
        .presetFull      (presetFull),
        .counterFreeze   (counterFreeze),
        .counterSaturate (counterSaturate),
        .clearOnRead     (clearOnRead),
        .irq             (irq)
    );
    // Free-running 50 MHz clock.
    initial
        forever #10 clock = ~clock;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic frame(input logic [15:0] n);
        @(posedge clock);
        rxFrameDone  <= 1'b1;
        rxFrameBytes <= n;
        @(posedge clock);
        rxFrameDone  <= 1'b0;
    endtask
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Guards against a hang; no wait in this bench should come near it.
    initial
    begin
        #1000000;
        failures++;
        $display("BAD %0t timeout", $time);
        results();
    end
    // Main sequence of tests.
    initial
    begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rdChk(SCC_CTRL_OFS, 32'h0);
        rdChk(SCC_FRAME_OFS, 32'h0);
        wrReg(SCC_FRAME_OFS, 32'h5);
        rdChk(SCC_FRAME_OFS, 32'h0);
        rdChk(12'hFF0, 32'h0);
        $display("test reset done");
        wrReg(SCC_CTRL_OFS, 32'hFFFF_FFE2);
        rdChk(SCC_CTRL_OFS, 32'h0000_0022);
        wrReg(SCC_CTRL_OFS, 32'h0000_0032);
        rdChk(SCC_FRAME_OFS, 32'hFFFF_FFF0);
        rdChk(SCC_OCTET_OFS, 32'hFFFF_F800);
        frame(16'hFFFF);
        rdChk(SCC_OCTET_OFS, 32'hFFFF_FFFF);
        rdChk(SCC_FRAME_OFS, 32'hFFFF_FFF1);
        wrReg(SCC_CTRL_OFS, 32'h0000_0030);
        frame(16'h0800);
        rdChk(SCC_OCTET_OFS, 32'h0);
        $display("test preset done");
        wrReg(SCC_MASK_OFS, 32'h2);
        rdChk(SCC_STAT_OFS, 32'h2);
        check({31'h0, irq}, 32'h1);
        wrReg(SCC_STAT_OFS, 32'h2);
        wrReg(SCC_MASK_OFS, 32'h0);
        rdChk(SCC_STAT_OFS, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test irq done");
        wrReg(SCC_CTRL_OFS, 32'h10);
        rdChk(SCC_FRAME_OFS, 32'h7FFF_FFF0);
        rdChk(SCC_OCTET_OFS, 32'h7FFF_F800);
        wrReg(SCC_CTRL_OFS, 32'h0C);
        frame(16'h0040);
        rdChk(SCC_FRAME_OFS, 32'h7FFF_FFF0);
        rdChk(SCC_FRAME_OFS, 32'h0);
        rdChk(SCC_OCTET_OFS, 32'h7FFF_F800);
        wrReg(SCC_CTRL_OFS, 32'h0);
        frame(16'h0040);
        rdChk(SCC_FRAME_OFS, 32'h1);
        rdChk(SCC_OCTET_OFS, 32'h40);
        $display("test freeze done");
        // A preset that meets a frame in the same cycle wins and the frame is dropped.
        @(posedge clock);
        addr         <= SCC_CTRL_OFS;
        wdata        <= 32'h10;
        wr           <= 1'b1;
        @(posedge clock);
        wr           <= 1'b0;
        rxFrameDone  <= 1'b1;
        rxFrameBytes <= 16'h0800;
        @(posedge clock);
        rxFrameDone  <= 1'b0;
        rdChk(SCC_FRAME_OFS, 32'h7FFF_FFF0);
        rdChk(SCC_OCTET_OFS, 32'h7FFF_F800);
        rdChk(SCC_STAT_OFS, 32'h0);
        frame(16'h0800);
        rdChk(SCC_STAT_OFS, 32'h2);
        repeat (15) frame(16'h0000);
        rdChk(SCC_FRAME_OFS, 32'h8000_0000);
        rdChk(SCC_STAT_OFS, 32'h3);
        rdChk(SCC_OCTET_OFS, 32'h8000_0000);
        $display("test priority done");
        wrReg(SCC_CTRL_OFS, 32'h1);
        rdChk(SCC_FRAME_OFS, 32'h0);
        rdChk(SCC_OCTET_OFS, 32'h0);
        $display("test clear done");
        results();
    end
endmodule
bind scc_stat_counter_control scc_ctrl_asserts u_asserts
(
    .clock           (clock),
    .nrst            (nrst),
    .addr            (addr),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .counterClear    (counterClear),
    .counterPreset   (counterPreset),
    .presetFull      (presetFull),
    .counterFreeze   (counterFreeze),
    .counterSaturate (counterSaturate),
    .clearOnRead     (clearOnRead),
    .irq             (irq)
);
`default_nettype wire
